//--- usbht_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USBHT_PARAMS_SVH
`define USBHT_PARAMS_SVH

// ==========================================================================
// Register offsets
`define USBHT_OFF_FRAME_OPT     8'h40
`define USBHT_OFF_EOP_TRAP      8'h41
`define USBHT_OFF_TX_HOLD       8'h42
`define USBHT_OFF_UNDERRUN      8'h43
`define USBHT_OFF_CRC_FRAME_END_GUARD_POINT    8'h48
`define USBHT_OFF_CLK_PME       8'h49
`define USBHT_OFF_TIMEOUT       8'h4a
`define USBHT_OFF_CLK_GATE      8'h4b
`define USBHT_OFF_SPARE         8'h4c
`define USBHT_OFF_RELEASE       8'h60
`define USBHT_OFF_PM_CAP        8'h80
`define USBHT_OFF_PM_STATE      8'h84

// ==========================================================================
// Reset values
`define USBHT_RST_FRAME_OPT     8'h40
`define USBHT_RST_EOP_TRAP      8'h12
`define USBHT_RST_TX_HOLD       8'h03
`define USBHT_RST_UNDERRUN      8'h00
`define USBHT_RST_CRC_FRAME_END_GUARD_POINT    8'h80
`define USBHT_RST_CLK_PME       8'h0b
`define USBHT_RST_TIMEOUT       8'ha0
`define USBHT_RST_CLK_GATE      8'h8b
`define USBHT_RST_SPARE         8'h00
`define USBHT_RELEASE_NUM       8'h10
`define USBHT_PM_CAP_D3C        32'hffc20001
`define USBHT_PM_CAP_NO_D3C     32'h7e0a0001
`define USBHT_RST_PM_STATE      2'h0

// ==========================================================================
// Writable masks (read-only bits stay fixed)
`define USBHT_WMASK_EOP_TRAP    8'hfe

// ==========================================================================
// Field positions
`define USBHT_B_BABBLE          6
`define USBHT_B_FRAME_SEL       4
`define USBHT_B_LEN_OPT         3
`define USBHT_B_LAT_OPT         2
`define USBHT_B_DMA_OPT         1
`define USBHT_B_EOP_OPT         7
`define USBHT_B_TRAP_OPT        2
`define USBHT_B_A20_OPT         1
`define USBHT_B_HOLD            2
`define USBHT_B_CONT_UNDER      3
`define USBHT_B_CRC_NOT_STUFF   2
`define USBHT_B_BAD_CRC5        2
`define USBHT_B_GUARD_LONG      1
`define USBHT_B_ZERO_CRC        0
`define USBHT_B_LS_BYPASS       5
`define USBHT_B_DIV_RST         4
`define USBHT_B_EHCI_PME        1
`define USBHT_B_UHCI_PME        0
`define USBHT_B_TO_LSB          3
`define USBHT_B_STOP_HALT       1
`define USBHT_B_EXT_CLK         0
`define USBHT_B_PD66            6
`define USBHT_B_PD33            5
`define USBHT_B_AUTO_STOP       0

// ==========================================================================
// Sizes and timing
`define USBHT_MAX_LEN_LONG      11'd1280
`define USBHT_MAX_LEN_SHORT     11'd1023
`define USBHT_SMALL_PKT         11'd64
`define USBHT_BURST_SHORT       5'd8
`define USBHT_BURST_LONG        5'd16
`define USBHT_FRAME_US_LONG     1000
`define USBHT_FRAME_US_SHORT    100
`define USBHT_CLK_MHZ           200
`define USBHT_FS_DIV            4
`define USBHT_GUARD_NORMAL      16'd600
`define USBHT_GUARD_LONG        16'd800

`endif

//--- usbht_pkg.sv
// Types shared by the tuning register block
package usbht_pkg;

    typedef enum logic [1:0] {
        USBHT_D0     = 2'b00,
        USBHT_RSV1   = 2'b01,
        USBHT_RSV2   = 2'b10,
        USBHT_D3_HOT = 2'b11
    } usbht_pstate_e;

    typedef enum logic [1:0] {
        USBHT_A20_IDLE = 2'b00,
        USBHT_A20_C1   = 2'b01,
        USBHT_A20_C2   = 2'b10,
        USBHT_A20_C3   = 2'b11
    } usbht_a20_e;

    // Configuration access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } usbht_cfg_req_s;

    // Controls steering the frame timer, transmitter, clocks and bus mastering
    typedef struct packed {
        logic        frame_short;
        logic [10:0] max_td_len;
        logic [4:0]  burst_dw;
        logic        low_latency_fifo;
        logic        accept_stuff_before_eop;
        logic        hold_until_threshold;
        logic        continue_on_underrun;
        logic        crc_err_on_underrun;
        logic        bad_crc5_after_underrun;
        logic        zero_bad_crc;
        logic        ls_use_internal_clk;
        logic        use_ext_60mhz;
        logic        stop_master_on_halt;
        logic        clock_auto_stop;
        logic        fast_bus_clock_dynamic_powerdown_enable;
        logic        slow_bus_clock_dynamic_powerdown_enable;
    } usbht_ctrl_s;

endpackage

//--- usbht_regs.sv
// Tuning registers of a full/low-speed host controller with their live effects
`timescale 1ns/1ps
`include "usbht_params.svh"

module usbht_regs
    import usbht_pkg::*;
#(
    parameter int FRAME_US_LONG  = `USBHT_FRAME_US_LONG,
    parameter int FRAME_US_SHORT = `USBHT_FRAME_US_SHORT
) (
    input  wire logic           sys_clk,
    input  wire logic           arst_n,
    input  wire usbht_cfg_req_s cfg_req,
    output logic [31:0]         cfg_rdata,
    output logic                cfg_rvalid,
    output usbht_ctrl_s         ctrl,
    input  wire logic           eof_activity,
    input  wire logic [3:0]     port_enabled,
    input  wire logic [1:0]     babble_port,
    output logic [3:0]          port_disable,
    input  wire logic           stuff_err_near_eop,
    output logic                packet_accept_stuff,
    input  wire logic [3:0]     kbd_access,
    input  wire logic [3:0]     kbd_trap_enable,
    output logic [3:0]          kbd_trap_set,
    input  wire logic           a20_cmd_valid,
    input  wire logic [7:0]     a20_cmd_port,
    input  wire logic [7:0]     a20_cmd_data,
    output logic                a20_seq_done,
    input  wire logic           fifo_at_threshold,
    input  wire logic           tx_underrun,
    output logic                tx_allow,
    output logic                tx_keep_going,
    output logic                tx_bad_crc,
    output logic [15:0]         tx_crc16_value,
    output logic                sof_bad_crc5,
    output logic                frame_tick,
    output logic                guard_block,
    input  wire logic           ls_mode,
    input  wire logic           bus_idle_tick,
    input  wire logic           bus_activity,
    output logic                bus_timeout,
    input  wire logic           ctrl_halted,
    output logic                bus_master_allow,
    output logic                div12_reset,
    output logic                fs_tick,
    output logic                clocks_stopped,
    output logic [1:0]          power_state
);

    // ======================================================================
    // Register storage
    logic [7:0]  frame_fifo_dma_options;
    logic [7:0]  eop_trap_a20_options;
    logic [7:0]  transmit_hold_control;
    logic [7:0]  underrun_data_control;
    logic [7:0]  underrun_crc_frame_end_guard_point_control;
    logic [7:0]  clock_source_pme_control;
    logic [7:0]  bus_timeout_control;
    logic [7:0]  clock_gating_control;
    logic [7:0]  spare_control;
    logic [1:0]  power_state_select;

    localparam int FRAME_CYC_LONG  = FRAME_US_LONG * `USBHT_CLK_MHZ;
    localparam int FRAME_CYC_SHORT = FRAME_US_SHORT * `USBHT_CLK_MHZ;

    logic        wr_go;
    logic        d3cold_pme_support_flag;
    logic [31:0] power_capability;
    logic [7:0]  next_clk_pme;

    assign wr_go = cfg_req.wr && cfg_req.be[0];
    assign d3cold_pme_support_flag = clock_source_pme_control[`USBHT_B_UHCI_PME];
    assign power_capability = d3cold_pme_support_flag ? `USBHT_PM_CAP_D3C
                                                      : `USBHT_PM_CAP_NO_D3C;
    assign next_clk_pme = cfg_req.wdata[7:0];

    // ======================================================================
    // Register writes (byte lane 0 carries each 8-bit register)
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_fifo_dma_options      <= `USBHT_RST_FRAME_OPT;
            eop_trap_a20_options        <= `USBHT_RST_EOP_TRAP;
            transmit_hold_control       <= `USBHT_RST_TX_HOLD;
            underrun_data_control       <= `USBHT_RST_UNDERRUN;
            underrun_crc_frame_end_guard_point_control <= `USBHT_RST_CRC_FRAME_END_GUARD_POINT;
            clock_source_pme_control    <= `USBHT_RST_CLK_PME;
            bus_timeout_control         <= `USBHT_RST_TIMEOUT;
            clock_gating_control        <= `USBHT_RST_CLK_GATE;
            spare_control               <= `USBHT_RST_SPARE;
            power_state_select          <= `USBHT_RST_PM_STATE;
        end else if (wr_go) begin
            case (cfg_req.addr)
                `USBHT_OFF_FRAME_OPT:  frame_fifo_dma_options <= cfg_req.wdata[7:0];
                `USBHT_OFF_EOP_TRAP: begin
                    eop_trap_a20_options <= cfg_req.wdata[7:0] & `USBHT_WMASK_EOP_TRAP;
                end
                `USBHT_OFF_TX_HOLD:    transmit_hold_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_UNDERRUN:   underrun_data_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_CRC_FRAME_END_GUARD_POINT: underrun_crc_frame_end_guard_point_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_CLK_PME:    clock_source_pme_control <= next_clk_pme;
                `USBHT_OFF_TIMEOUT:    bus_timeout_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_CLK_GATE:   clock_gating_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_SPARE:      spare_control <= cfg_req.wdata[7:0];
                `USBHT_OFF_PM_STATE:   power_state_select <= cfg_req.wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // Register reads, one cycle after the request; unmapped reads return zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata  <= 32'h0;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd) begin
                case (cfg_req.addr)
                    `USBHT_OFF_FRAME_OPT:  cfg_rdata <= {24'h0, frame_fifo_dma_options};
                    `USBHT_OFF_EOP_TRAP:   cfg_rdata <= {24'h0, eop_trap_a20_options};
                    `USBHT_OFF_TX_HOLD:    cfg_rdata <= {24'h0, transmit_hold_control};
                    `USBHT_OFF_UNDERRUN:   cfg_rdata <= {24'h0, underrun_data_control};
                    `USBHT_OFF_CRC_FRAME_END_GUARD_POINT: cfg_rdata <= {24'h0, underrun_crc_frame_end_guard_point_control};
                    `USBHT_OFF_CLK_PME:    cfg_rdata <= {24'h0, clock_source_pme_control};
                    `USBHT_OFF_TIMEOUT:    cfg_rdata <= {24'h0, bus_timeout_control};
                    `USBHT_OFF_CLK_GATE:   cfg_rdata <= {24'h0, clock_gating_control};
                    `USBHT_OFF_SPARE:      cfg_rdata <= {24'h0, spare_control};
                    `USBHT_OFF_RELEASE:    cfg_rdata <= {24'h0, `USBHT_RELEASE_NUM};
                    `USBHT_OFF_PM_CAP:     cfg_rdata <= power_capability;
                    `USBHT_OFF_PM_STATE:   cfg_rdata <= {30'h0, power_state_select};
                    default:               cfg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // ======================================================================
    // Decoded controls
    always_comb begin
        ctrl.frame_short = frame_fifo_dma_options[`USBHT_B_FRAME_SEL];
        ctrl.max_td_len  = frame_fifo_dma_options[`USBHT_B_LEN_OPT]
                         ? `USBHT_MAX_LEN_SHORT : `USBHT_MAX_LEN_LONG;
        ctrl.burst_dw    = frame_fifo_dma_options[`USBHT_B_DMA_OPT]
                         ? `USBHT_BURST_LONG : `USBHT_BURST_SHORT;
        ctrl.low_latency_fifo = !frame_fifo_dma_options[`USBHT_B_LAT_OPT];
        ctrl.accept_stuff_before_eop = !eop_trap_a20_options[`USBHT_B_EOP_OPT];
        ctrl.hold_until_threshold = !transmit_hold_control[`USBHT_B_HOLD];
        ctrl.continue_on_underrun = !underrun_data_control[`USBHT_B_CONT_UNDER];
        ctrl.crc_err_on_underrun = !underrun_data_control[`USBHT_B_CRC_NOT_STUFF];
        ctrl.bad_crc5_after_underrun = !underrun_crc_frame_end_guard_point_control[`USBHT_B_BAD_CRC5];
        ctrl.zero_bad_crc = underrun_crc_frame_end_guard_point_control[`USBHT_B_ZERO_CRC];
        ctrl.ls_use_internal_clk = clock_source_pme_control[`USBHT_B_LS_BYPASS];
        ctrl.use_ext_60mhz = bus_timeout_control[`USBHT_B_EXT_CLK];
        ctrl.stop_master_on_halt = bus_timeout_control[`USBHT_B_STOP_HALT];
        ctrl.clock_auto_stop = clock_gating_control[`USBHT_B_AUTO_STOP];
        ctrl.fast_bus_clock_dynamic_powerdown_enable = clock_gating_control[`USBHT_B_PD66];
        ctrl.slow_bus_clock_dynamic_powerdown_enable = clock_gating_control[`USBHT_B_PD33];
    end

    assign power_state = power_state_select;

    // ======================================================================
    // Babble: disable the port whose activity runs into end of frame
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_port
            assign port_disable[gp] = eof_activity && port_enabled[gp]
                                   && (babble_port == 2'(gp))
                                   && !frame_fifo_dma_options[`USBHT_B_BABBLE];
        end
    endgenerate

    assign packet_accept_stuff = stuff_err_near_eop && ctrl.accept_stuff_before_eop;

    // Trap status set; enables only matter when the option asks for them
    assign kbd_trap_set = kbd_access & (eop_trap_a20_options[`USBHT_B_TRAP_OPT]
                          ? kbd_trap_enable : 4'hf);

    // ======================================================================
    // Pass-through sequence: D1 to 64, data to 60, any third command, FFh to 64 (optionally skipped)
    usbht_a20_e a20_state;
    logic       a20_skip_last;

    assign a20_skip_last = eop_trap_a20_options[`USBHT_B_A20_OPT];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            a20_state    <= USBHT_A20_IDLE;
            a20_seq_done <= 1'b0;
        end else begin
            a20_seq_done <= 1'b0;
            if (a20_cmd_valid) begin
                case (a20_state)
                    USBHT_A20_IDLE: begin
                        if (a20_cmd_port == 8'h64 && a20_cmd_data == 8'hd1) begin
                            a20_state <= USBHT_A20_C1;
                        end
                    end
                    USBHT_A20_C1: begin
                        if (a20_cmd_port == 8'h60) begin
                            a20_state <= USBHT_A20_C2;
                        end else begin
                            a20_state <= USBHT_A20_IDLE;
                        end
                    end
                    USBHT_A20_C2: begin
                        if (a20_skip_last) begin
                            a20_seq_done <= 1'b1;
                            a20_state    <= USBHT_A20_IDLE;
                        end else begin
                            a20_state <= USBHT_A20_C3;
                        end
                    end
                    USBHT_A20_C3: begin
                        a20_seq_done <= (a20_cmd_port == 8'h64 && a20_cmd_data == 8'hff);
                        a20_state    <= USBHT_A20_IDLE;
                    end
                    default: a20_state <= USBHT_A20_IDLE;
                endcase
            end
        end
    end

    // ======================================================================
    // Frame timer and guard point
    logic [31:0] frame_cnt;
    logic [31:0] frame_len;
    logic [15:0] guard_cyc;

    assign frame_len = ctrl.frame_short ? FRAME_CYC_SHORT[31:0] : FRAME_CYC_LONG[31:0];
    assign guard_cyc = underrun_crc_frame_end_guard_point_control[`USBHT_B_GUARD_LONG]
                     ? `USBHT_GUARD_LONG : `USBHT_GUARD_NORMAL;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_cnt  <= 32'h0;
            frame_tick <= 1'b0;
        end else begin
            frame_tick <= (frame_cnt >= frame_len - 32'h1);
            frame_cnt  <= (frame_cnt >= frame_len - 32'h1) ? 32'h0 : frame_cnt + 32'h1;
        end
    end

    // Guard keeps a 64-byte transaction from overrunning the frame end
    assign guard_block = (frame_cnt + {16'h0, guard_cyc}) >= frame_len;

    // ======================================================================
    // Transmit gating and underrun handling
    logic underrun_seen;

    assign tx_allow = (!ctrl.hold_until_threshold || fifo_at_threshold) && !guard_block;
    assign tx_keep_going = tx_underrun && ctrl.continue_on_underrun;
    assign tx_bad_crc = tx_underrun && ctrl.crc_err_on_underrun;
    assign tx_crc16_value = ctrl.zero_bad_crc ? 16'h0000 : 16'hdead;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            underrun_seen <= 1'b0;
        end else if (tx_underrun) begin
            underrun_seen <= 1'b1;
        end else if (frame_tick) begin
            underrun_seen <= 1'b0;
        end
    end

    // Set wins: an underrun in the tick cycle is held for the next frame
    assign sof_bad_crc5 = frame_tick && underrun_seen && ctrl.bad_crc5_after_underrun;

    // ======================================================================
    // Divide-by-4 tick divider (50 MHz from the 200 MHz clock) and its reset on a 0 to 1 write
    logic       div_rst_q;
    logic [1:0] div_cnt;

    assign div12_reset = clock_source_pme_control[`USBHT_B_DIV_RST] && !div_rst_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_rst_q <= 1'b0;
            div_cnt   <= 2'h0;
            fs_tick   <= 1'b0;
        end else begin
            div_rst_q <= clock_source_pme_control[`USBHT_B_DIV_RST];
            if (div12_reset) begin
                div_cnt <= 2'h0;
                fs_tick <= 1'b0;
            end else begin
                div_cnt <= div_cnt + 2'h1;
                fs_tick <= (div_cnt == 2'(`USBHT_FS_DIV - 1));
            end
        end
    end

    // ======================================================================
    // Bus timeout counted in the bit-time ticks of the current speed
    logic [4:0] to_cnt;
    logic [4:0] to_limit;

    assign to_limit = bus_timeout_control[7:`USBHT_B_TO_LSB];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            to_cnt      <= 5'h0;
            bus_timeout <= 1'b0;
        end else if (bus_activity) begin
            to_cnt      <= 5'h0;
            bus_timeout <= 1'b0;
        end else if (bus_idle_tick && !bus_timeout) begin
            // bus_idle_tick is the 12 MHz or 1.5 MHz tick, chosen by ls_mode outside
            if (to_cnt + 5'h1 >= to_limit) begin
                bus_timeout <= 1'b1;
            end
            to_cnt <= to_cnt + 5'h1;
        end
    end

    // ======================================================================
    // Bus mastering and clock stop
    assign bus_master_allow = !(ctrl.stop_master_on_halt && ctrl_halted);
    assign clocks_stopped = ctrl.clock_auto_stop && !bus_activity && !ls_mode
                          ? 1'b1 : ctrl.clock_auto_stop && !bus_activity;

endmodule

//--- usbht_sva.sv
// Port checker for the tuning register block
`timescale 1ns/1ps
module usbht_sva
    import usbht_pkg::*;
(
    input wire logic           sys_clk,
    input wire logic           arst_n,
    input wire usbht_cfg_req_s cfg_req,
    input wire logic [31:0]    cfg_rdata,
    input wire logic           cfg_rvalid,
    input wire usbht_ctrl_s    ctrl,
    input wire logic           stuff_err_near_eop,
    input wire logic           packet_accept_stuff,
    input wire logic           fifo_at_threshold,
    input wire logic           tx_allow,
    input wire logic           tx_bad_crc,
    input wire logic [15:0]    tx_crc16_value,
    input wire logic           sof_bad_crc5,
    input wire logic           frame_tick,
    input wire logic           ctrl_halted,
    input wire logic           bus_master_allow,
    input wire logic           div12_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // Access and decode
    property p_rd; cfg_req.rd && cfg_req.addr == 8'h80 |=> cfg_rvalid && (cfg_rdata == 32'hffc20001 || cfg_rdata == 32'h7e0a0001); endproperty
    a_rd: assert property (p_rd) else $error("capability read wrong");
    property p_opt; cfg_req.wr && cfg_req.be[0] && cfg_req.addr == 8'h40 |=> ctrl.frame_short == $past(cfg_req.wdata[4]) && ctrl.max_td_len == ($past(cfg_req.wdata[3]) ? 11'd1023 : 11'd1280) && ctrl.burst_dw == ($past(cfg_req.wdata[1]) ? 5'd16 : 5'd8); endproperty
    a_opt: assert property (p_opt) else $error("frame options not decoded");
    // ==========
    // Packet and bus effects
    property p_eop; packet_accept_stuff == (stuff_err_near_eop && ctrl.accept_stuff_before_eop); endproperty
    a_eop: assert property (p_eop) else $error("stuff error acceptance wrong");
    property p_crc; tx_bad_crc |-> (ctrl.zero_bad_crc ? tx_crc16_value == 16'h0000 : tx_crc16_value != 16'h0000); endproperty
    a_crc: assert property (p_crc) else $error("bad crc kind wrong");
    property p_hold; ctrl.hold_until_threshold && !fifo_at_threshold |-> !tx_allow; endproperty
    a_hold: assert property (p_hold) else $error("sent below threshold");
    property p_sof; sof_bad_crc5 |-> frame_tick; endproperty
    a_sof: assert property (p_sof) else $error("bad crc5 outside start of frame");
    property p_halt; ctrl_halted && ctrl.stop_master_on_halt |-> !bus_master_allow; endproperty
    a_halt: assert property (p_halt) else $error("master cycles while halted");
    // Reset pulse must not stretch, or the divider would stay parked
    property p_div; div12_reset |=> !div12_reset; endproperty
    a_div: assert property (p_div) else $error("divider reset held");
endmodule
bind usbht_regs usbht_sva i_sva (.*);

//--- usbht_far_end.sv
// Far-side traffic: bus events, FIFO state and port status
`timescale 1ns/1ps
module usbht_far_end (
    input  wire logic  sys_clk,
    output logic       eof_activity, stuff_err_near_eop, fifo_at_threshold, tx_underrun,
    output logic       bus_activity, bus_idle_tick, ctrl_halted, ls_mode,
    output logic [3:0] port_enabled,
    output logic [1:0] babble_port
);
    // Fresh values every cycle, so no stale line ever looks steady
    initial forever begin
        {eof_activity, stuff_err_near_eop, fifo_at_threshold, tx_underrun, bus_activity,
         bus_idle_tick, ctrl_halted, ls_mode, port_enabled, babble_port} = 14'($urandom);
        @(negedge sys_clk);
    end
endmodule

//--- usbht_regs_tb.sv
// Self-checking bench for the tuning register block
`timescale 1ns/1ps
`include "usbht_params.svh"
module usbht_regs_tb
    import usbht_pkg::*;
;
    logic sys_clk, arst_n, cfg_rvalid, a20_seq_done, ls_mode, a20_cmd_valid, eof_activity;
    logic stuff_err_near_eop, packet_accept_stuff, fifo_at_threshold, tx_underrun, tx_allow;
    logic tx_keep_going, tx_bad_crc, sof_bad_crc5, frame_tick, guard_block, bus_idle_tick;
    logic bus_activity, bus_timeout, ctrl_halted, bus_master_allow, div12_reset, fs_tick;
    logic clocks_stopped;
    usbht_cfg_req_s cfg_req;
    usbht_ctrl_s    ctrl;
    logic [31:0]    cfg_rdata, q;
    logic [15:0]    tx_crc16_value;
    logic [7:0]     a20_cmd_port, a20_cmd_data, d, sh [9];
    logic [3:0]     port_enabled, port_disable, kbd_access, kbd_trap_enable, kbd_trap_set, bab_exp;
    logic [1:0]     babble_port, power_state;
    int             errors = 0, n_compared = 0, n_div = 0, exp_div = 0, i, to_c = 0, to_e = 0;
    // Do-not-program bits stay at reset, so the writable mask excludes them
    localparam logic [7:0] offs [9] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c};
    localparam logic [7:0] rstv [9] = '{8'h40, 8'h12, 8'h03, 8'h00, 8'h80, 8'h0b, 8'ha0, 8'h8b, 8'h00};
    localparam logic [7:0] wmsk [9] = '{8'h5e, 8'h86, 8'h04, 8'h0c, 8'h07, 8'h33, 8'hfb, 8'h61, 8'h00};
    localparam logic [7:0] ro [4] = '{8'h60, 8'h80, 8'h84, 8'h50};
    localparam logic [31:0] roe [4] = '{32'h10, 32'hffc20001, 32'h0, 32'h0};
    localparam logic [15:0] a20s [4] = '{16'h64d1, 16'h60df, 16'h6400, 16'h64ff};
    usbht_regs #(.FRAME_US_LONG(10), .FRAME_US_SHORT(1)) i_dut (.*);
    usbht_far_end i_far (.*);
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (div12_reset) n_div++;
    // Live effects checked every rising edge against the software shadows of the registers
    always @(posedge sys_clk) if (arst_n) begin
        bab_exp = {3'h0, eof_activity && !sh[0][6]} << babble_port;
        chk("babble", bab_exp & port_enabled, port_disable);
        chk("keep going", tx_underrun && !sh[3][3], tx_keep_going);
        chk("crc error", tx_underrun && !sh[3][2], tx_bad_crc);
        chk("crc value", sh[4][0] ? 32'h0 : 32'hdead, tx_crc16_value);
        chk("master", !(sh[6][1] && ctrl_halted), bus_master_allow);
        chk("clock stop", sh[7][0] && !bus_activity, clocks_stopped);
        chk("latency", !sh[0][2], ctrl.low_latency_fifo);
        chk("ls clock", sh[5][5], ctrl.ls_use_internal_clk);
        chk("ext clock", sh[6][0], ctrl.use_ext_60mhz);
        chk("timeout", to_e, bus_timeout);
        if (bus_activity) begin
            to_c = 0;
            to_e = 0;
        end else if (bus_idle_tick && to_e == 0) begin
            to_e = int'(to_c + 1 >= sh[6][7:3]);
            to_c++;
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dv);
        cfg_req = '{rd: !w, wr: w, addr: a, be: 4'h1, wdata: {24'h0, dv}};
        @(negedge sys_clk);
        q = cfg_rdata;
        if (!w) chk("rvalid", 1, cfg_rvalid);
    endtask
    task automatic per(input int n);
        int c;
        c = 0;
        while (frame_tick !== 1'b1) @(negedge sys_clk);
        do begin
            @(negedge sys_clk);
            c++;
        end while (frame_tick !== 1'b1);
        chk("frame period", n, c);
    endtask
    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        {cfg_req, kbd_access, kbd_trap_enable, a20_cmd_valid, a20_cmd_port, a20_cmd_data} = '0;
        arst_n = 0;
        sh = rstv;
        void'($urandom(32'hef7411af));
        repeat (8) @(negedge sys_clk);
        arst_n = 1;
        foreach (offs[k]) begin
            acc(0, offs[k], 8'h00);
            chk("reset value", {24'h0, rstv[k]}, q);
        end
        for (int r = 0; r < 2; r++) begin
            foreach (ro[j]) begin
                acc(0, ro[j], 8'h00);
                chk("fixed read", (j == 2 && r == 1) ? 32'h3 : roe[j], q);
                acc(1, ro[j], 8'h03);
            end
        end
        acc(1, 8'h84, 8'h00);
        repeat (40) begin
            i = $urandom_range(8);
            d = (rstv[i] & ~wmsk[i]) | (8'($urandom) & wmsk[i]);
            if (i == 5 && d[4] && !sh[5][4]) exp_div++;
            kbd_access = 4'($urandom);
            kbd_trap_enable = 4'($urandom);
            acc(1, offs[i], d);
            sh[i] = d;
            acc(0, offs[i], 8'h00);
            chk("readback", {24'h0, d}, q);
            chk("trap", sh[1][2] ? kbd_access & kbd_trap_enable : kbd_access, kbd_trap_set);
            acc(0, 8'h80, 8'h00);
            chk("pm capability", sh[5][0] ? 32'hffc20001 : 32'h7e0a0001, q);
        end
        // Option 1 ends the sequence on the third command, option 0 needs the fourth
        for (int o = 0; o < 2; o++) begin
            acc(1, 8'h41, o ? 8'h10 : 8'h12);
            cfg_req = '0;
            foreach (a20s[k]) begin
                {a20_cmd_valid, a20_cmd_port, a20_cmd_data} = {1'b1, a20s[k]};
                @(negedge sys_clk);
                chk("a20 done", k == 2 + o, a20_seq_done);
            end
            a20_cmd_valid = 0;
        end
        acc(1, 8'h40, 8'h40);
        cfg_req = '0;
        per(10 * `USBHT_CLK_MHZ);
        acc(1, 8'h40, 8'h50);
        cfg_req = '0;
        per(1 * `USBHT_CLK_MHZ);
        chk("divider resets", exp_div, n_div);
        finish_test();
    end
endmodule
